// File: dsc_pkg.sv
// Purpose: Shared constants for the serial control pin block.
// Assumes: Frames are sent most significant bit first.
// Notes: Frame payload is an 8-bit address above a 16-bit data field.
`default_nettype none
package dsc_pkg;
    localparam int FRAME_BITS = 24;
    localparam int FRAME_BITS_CHK = 32;
    localparam int SHIFT_W = 32;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] LEN_PLAIN = 6'h18;
    localparam logic [CNT_W-1:0] LEN_CHK = 6'h20;
    localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;
    localparam int ADDR_MSB = 23;
    localparam int ADDR_LSB = 16;
    localparam int DATA_MSB = 15;
    localparam int CHK_LSB = 8;
    // Register addresses inside the serial frame.
    localparam logic [7:0] ADDR_DAC_INPUT = 8'h01;
    localparam logic [7:0] ADDR_GENERAL_CONFIG_ONE = 8'h02;
    localparam logic [7:0] ADDR_READBACK_SEL = 8'h1F;
    // Fields of general_config_one.
    localparam int CFG_W = 2;
    localparam int CFG_MODEM_PATH_ENABLE = 0;
    localparam int CFG_CHECK_ENABLE = 1;
    localparam logic [CFG_W-1:0] CFG_RESET = 2'h0;
    localparam logic [15:0] CODE_RESET = 16'h0000;
    localparam logic [7:0] RB_SEL_RESET = 8'h00;
endpackage
`default_nettype wire

// File: dsc_shift_if.sv
// Purpose: Carrier between the pin front end and the serial shifter.
// Assumes: All signals are on the core clock.
// Notes: None.
`default_nettype none
interface dsc_shift_if;
    logic fall_stb;
    logic frame_act;
    logic sdi;
    logic len_chk;
    logic [23:0] load_word;
    logic done;
    logic [31:0] rx_word;
    logic sdo_bit;
    modport front (output fall_stb, frame_act, sdi, len_chk, load_word,
                   input done, rx_word, sdo_bit);
    modport shifter (input fall_stb, frame_act, sdi, len_chk, load_word,
                     output done, rx_word, sdo_bit);
endinterface
`default_nettype wire

// File: dsc_shifter.sv
// Purpose: Shifts serial frames in and the readback word out.
// Assumes: Strobes come from synchronised pins on the core clock.
// Notes: A frame of the wrong length is dropped without a done pulse.
`default_nettype none
module dsc_shifter
    import dsc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic i_hw_rst,
    dsc_shift_if.shifter sh
);
    typedef struct packed {
        logic act;
        logic [CNT_W-1:0] cnt;
        logic [SHIFT_W-1:0] rx;
        logic [SHIFT_W-1:0] tx;
        logic done;
    } dsc_shift_s;

    dsc_shift_s st_ff;
    dsc_shift_s nxt_st;
    logic [CNT_W-1:0] len;

    assign len = sh.len_chk ? LEN_CHK : LEN_PLAIN;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        nxt_st.act = sh.frame_act;
        if (sh.frame_act && !st_ff.act) begin
            nxt_st.cnt = '0;
            nxt_st.tx = {sh.load_word, 8'h00};
        end else if (sh.frame_act && sh.fall_stb) begin // RULE9
            nxt_st.rx = {st_ff.rx[SHIFT_W-2:0], sh.sdi}; // RULE1
            // Zeros fill from below, so edges past the frame give 0.
            nxt_st.tx = {st_ff.tx[SHIFT_W-2:0], 1'b0}; // RULE4 RULE11
            if (st_ff.cnt != CNT_MAX) begin
                nxt_st.cnt = st_ff.cnt + 6'h01;
            end
        end else if (!sh.frame_act && st_ff.act) begin
            nxt_st.done = (st_ff.cnt == len);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            st_ff <= '0;
        end else if (i_ce) begin
            // The pin reset waits for an enabled cycle like all state.
            if (i_hw_rst) begin // RULE5
                st_ff <= '0;
            end else begin
                st_ff <= nxt_st;
            end
        end
    end

    assign sh.done = st_ff.done;
    assign sh.rx_word = st_ff.rx;
    assign sh.sdo_bit = st_ff.tx[SHIFT_W-1];
endmodule
`default_nettype wire

// File: dsc_serial_control.sv
// Purpose: Pin-level serial control of a single-channel output converter.
// Assumes: Core clock far faster than the serial clock on the pins.
// Notes: Check code bits are accepted but not verified.
//   Frame address 0x01 stages a code, 0x02 writes general_config_one
//   and 0x1F picks the readback source; other addresses are ignored.
//   A readback select outside those three returns the output code.
//   Every pin passes two flip-flops, so a pin event takes effect
//   two to three core cycles after it happens on the pin; frame writes and the data output take three to four.
// Notes on behaviour
// RULE1: Shift input bits on serial clock falling edges.
// RULE2: Host keeps write clock at most 50 MHz.
// RULE3: Host keeps read clock within 20/15 MHz.
// RULE4: Readback shifts serial register out on data output.
// RULE5: Low reset pin resets the device.
// RULE6: Load strobe copies staged code to output.
// RULE7: Host avoids load strobe near frame end.
// RULE8: Modem path off until its enable bit set.
// RULE9: Accept data only while frame select low.
// RULE10: Host sets data valid at falling edge.
// RULE11: Extra edges after frame output zero.
`default_nettype none
module dsc_serial_control
    import dsc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic i_sclk,
    input wire logic i_sdi,
    input wire logic i_sync_n,
    input wire logic i_load_output_n,
    input wire logic i_reset_pin_n,
    output logic o_sdo,
    output logic o_sdo_oe,
    output logic [15:0] o_dac_code,
    output logic o_modem_path_enable,
    output logic o_check_enable
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        // Pin synchronisers, two stages each, plus the edge history.
        logic [1:0] sclk_s;
        logic sclk_d;
        logic [1:0] sdi_s;
        logic [1:0] sync_s;
        logic [1:0] load_s;
        logic [1:0] rst_s;
        // Frame-written state and the registered pin drivers.
        logic [15:0] staged;
        logic [15:0] code;
        logic [CFG_W-1:0] cfg;
        logic [7:0] rb_sel;
        logic sdo;
        logic sdo_oe;
    } dsc_top_s;

    dsc_top_s st_ff;
    dsc_top_s nxt_st;
    dsc_shift_if sh_if ();
    logic hw_rst;
    logic [23:0] rx_pay;
    logic [7:0] rx_addr;
    logic [15:0] rx_data;
    logic [15:0] rb_data;
    logic [15:0] rb_cfg_word;
    logic [15:0] rb_sel_word;
    logic sclk_fall;
    logic frame_low;
    logic load_low;
    logic wr_code;
    logic wr_cfg;
    logic wr_sel;

    // ------------------------------------------------------------
    // Pin front end
    // ------------------------------------------------------------
    // Only the second stage of each synchroniser is read, so no logic
    // ever sees a value that may still be settling.
    assign hw_rst = !st_ff.rst_s[1];
    assign sclk_fall = st_ff.sclk_d && !st_ff.sclk_s[1];
    assign frame_low = !st_ff.sync_s[1];
    assign load_low = !st_ff.load_s[1];

    // ------------------------------------------------------------
    // Shifter hookup
    // ------------------------------------------------------------
    assign sh_if.fall_stb = sclk_fall;
    assign sh_if.frame_act = frame_low;
    assign sh_if.sdi = st_ff.sdi_s[1];
    assign sh_if.len_chk = st_ff.cfg[CFG_CHECK_ENABLE];
    assign sh_if.load_word = {st_ff.rb_sel, rb_data};

    // The shifter shares the clock enable and both resets with this level.
    dsc_shifter u_shifter (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_hw_rst(hw_rst),
        .sh(sh_if)
    );

    // ------------------------------------------------------------
    // Frame payload
    // ------------------------------------------------------------
    // With checking on, the payload sits above the trailing check byte.
    // The check byte itself is dropped: a frame of the right length is
    // trusted as it stands.
    assign rx_pay = st_ff.cfg[CFG_CHECK_ENABLE] ?
                    sh_if.rx_word[SHIFT_W-1:CHK_LSB] :
                    sh_if.rx_word[FRAME_BITS-1:0];
    assign rx_addr = rx_pay[ADDR_MSB:ADDR_LSB];
    assign rx_data = rx_pay[DATA_MSB:0];

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    // A write lands only on the done pulse of a frame of the right
    // length; unknown addresses fall through and change nothing.
    always_comb begin
        wr_code = 1'b0;
        wr_cfg = 1'b0;
        wr_sel = 1'b0;
        if (sh_if.done) begin
            case (rx_addr)
                ADDR_DAC_INPUT: wr_code = 1'b1;
                ADDR_GENERAL_CONFIG_ONE: wr_cfg = 1'b1;
                ADDR_READBACK_SEL: wr_sel = 1'b1;
                default: wr_code = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Readback mux
    // ------------------------------------------------------------
    // The word is captured at frame start, so a write in the same
    // frame shows up only in the next readback.
    assign rb_cfg_word = {14'h0000, st_ff.cfg};
    assign rb_sel_word = {8'h00, st_ff.rb_sel};

    always_comb begin
        case (st_ff.rb_sel)
            ADDR_DAC_INPUT: rb_data = st_ff.staged;
            ADDR_GENERAL_CONFIG_ONE: rb_data = rb_cfg_word;
            ADDR_READBACK_SEL: rb_data = rb_sel_word;
            default: rb_data = st_ff.code;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        // Anything not named below keeps its value.
        nxt_st.sclk_s = {st_ff.sclk_s[0], i_sclk};
        nxt_st.sclk_d = st_ff.sclk_s[1];
        nxt_st.sdi_s = {st_ff.sdi_s[0], i_sdi};
        nxt_st.sync_s = {st_ff.sync_s[0], i_sync_n};
        nxt_st.load_s = {st_ff.load_s[0], i_load_output_n};
        nxt_st.rst_s = {st_ff.rst_s[0], i_reset_pin_n};
        nxt_st.sdo = sh_if.sdo_bit; // RULE4
        // Drive the data output only inside a frame to share the line.
        nxt_st.sdo_oe = frame_low;
        if (wr_code) begin
            nxt_st.staged = rx_data;
        end
        if (wr_cfg) begin
            nxt_st.cfg = rx_data[CFG_W-1:0]; // RULE8
        end
        if (wr_sel) begin
            nxt_st.rb_sel = rx_data[7:0];
        end
        // The strobe is a level: the code follows the staged value for
        // as long as the pin stays low, not just on its falling edge.
        if (load_low) begin
            nxt_st.code = st_ff.staged; // RULE6
        end
        // The synchronisers keep running under a held reset pin, so the
        // release is seen and the block leaves reset cleanly.
        if (hw_rst) begin // RULE5
            nxt_st.staged = CODE_RESET;
            nxt_st.code = CODE_RESET;
            nxt_st.cfg = CFG_RESET; // RULE8
            nxt_st.rb_sel = RB_SEL_RESET;
            nxt_st.sdo = 1'b0;
            nxt_st.sdo_oe = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // The core reset wins over the clock enable; everything else in
    // the block waits for an enabled cycle.
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            // Synchronisers start at the idle pin levels, so no false
            // edge or frame is seen on the way out of reset.
            st_ff <= '0;
            st_ff.sclk_s <= 2'h3;
            st_ff.sclk_d <= 1'b1;
            st_ff.sync_s <= 2'h3;
            st_ff.load_s <= 2'h3;
            st_ff.rst_s <= 2'h3;
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output leaves straight from a register, so the pin timing
    // does not depend on the depth of the decode logic.
    assign o_sdo = st_ff.sdo;
    assign o_sdo_oe = st_ff.sdo_oe;
    assign o_dac_code = st_ff.code;
    assign o_modem_path_enable = st_ff.cfg[CFG_MODEM_PATH_ENABLE]; // RULE8
    assign o_check_enable = st_ff.cfg[CFG_CHECK_ENABLE];
endmodule
`default_nettype wire

// File: dsc_serial_control_sva.sv
// Purpose: Port checks for the serial control block.
// Assumes: Clock enable high in frames; serial clock low >= 3 cycles.
// Notes: Windows allow for the pin synchronisers.
`default_nettype none
module dsc_chk (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic i_sclk,
    input wire logic i_sync_n,
    input wire logic i_load_output_n,
    input wire logic i_reset_pin_n,
    input wire logic o_sdo,
    input wire logic o_sdo_oe,
    input wire logic [15:0] o_dac_code,
    input wire logic o_modem_path_enable,
    input wire logic o_check_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_resetn);
    property p_prst;
        (i_ce && !i_reset_pin_n)[*5] |-> !o_dac_code && !o_modem_path_enable;
    endproperty
    a_prst: assert property (p_prst) else $error("pin reset");
    property p_rst;
        $rose(i_resetn) |-> !o_dac_code && !o_check_enable && !o_sdo_oe;
    endproperty
    a_rst: assert property (p_rst) else $error("core reset");
    property p_hold;
        (i_load_output_n && i_reset_pin_n)[*6] |-> $stable(o_dac_code);
    endproperty
    a_hold: assert property (p_hold) else $error("code moved");
    property p_mod;
        $rose(o_modem_path_enable) |-> $past(i_sync_n, 2);
    endproperty
    a_mod: assert property (p_mod) else $error("modem early");
    property p_chk;
        $rose(o_check_enable) |-> $past(i_sync_n, 2);
    endproperty
    a_chk: assert property (p_chk) else $error("check early");
    property p_oe0;
        i_sync_n[*5] |-> !o_sdo_oe;
    endproperty
    a_oe0: assert property (p_oe0) else $error("sdo driven");
    property p_oe1;
        (!i_sync_n && i_reset_pin_n)[*5] |-> o_sdo_oe;
    endproperty
    a_oe1: assert property (p_oe1) else $error("sdo idle");
    property p_sdo;
        $changed(o_sdo) && !i_sync_n && !$past(i_sync_n, 12)
            |-> !$past(i_sclk, 3);
    endproperty
    a_sdo: assert property (p_sdo) else $error("sdo moved");
    c_load: cover property ($changed(o_dac_code));
    c_mod: cover property ($rose(o_modem_path_enable));
    c_chk: cover property ($rose(o_check_enable));
endmodule
bind dsc_serial_control dsc_chk chk_u (.i_core_clk, .i_resetn, .i_ce,
    .i_sclk, .i_sync_n, .i_load_output_n, .i_reset_pin_n, .o_sdo,
    .o_sdo_oe, .o_dac_code, .o_modem_path_enable, .o_check_enable);
`default_nettype wire

// File: dsc_host_model.sv
// Purpose: Host driving the serial port in whole core clock steps.
// Assumes: Serial clock idles high and stands still between frames.
// Notes: A released data line shows the inverse of its last bit.
`default_nettype none
module dsc_host_model (
    input wire logic i_clk,
    input wire logic i_sdo,
    output logic o_sclk,
    output logic o_sdi,
    output logic o_sync_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_sclk = 1'b1;
        o_sdi = 1'b0;
        o_sync_n = 1'b1;
    end
    // Period of 8 core cycles, 160 ns, stays under both read limits.
    task automatic xfer(input logic [31:0] w, input int n,
                        output logic [31:0] rd);
        rd = '0;
        @(posedge i_clk) o_sync_n <= 1'b0;
        repeat (4) @(posedge i_clk);
        for (int k = 0; k < n; k++) begin
            o_sdi <= w[31-k];
            repeat (4) @(posedge i_clk);
            rd = {rd[30:0], i_sdo};
            o_sclk <= 1'b0;
            repeat (4) @(posedge i_clk);
            o_sclk <= 1'b1;
        end
        repeat (4) @(posedge i_clk);
        o_sync_n <= 1'b1;
        o_sdi <= ~o_sdi;
        repeat (8) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

// File: tb_top.sv
// Purpose: Self-checking bench for the serial control block.
// Assumes: Clock enable dropped once, away from any frame.
// Notes: Random codes come from a fixed xorshift seed.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rstn, pin_rstn, ld_n, sclk, sdi, sync_n, ce;
    logic sdo, oe, mod_en, chk_en;
    logic [15:0] code, val, exp_code;
    logic [31:0] seed, rd;
    int miscompares, checks;
    dsc_serial_control dut_u (.i_core_clk(clk), .i_resetn(rstn),
        .i_ce(ce), .i_sclk(sclk), .i_sdi(sdi), .i_sync_n(sync_n),
        .i_load_output_n(ld_n), .i_reset_pin_n(pin_rstn), .o_sdo(sdo),
        .o_sdo_oe(oe), .o_dac_code(code), .o_modem_path_enable(mod_en),
        .o_check_enable(chk_en));
    dsc_host_model host_u (.i_clk(clk), .i_sdo(sdo), .o_sclk(sclk),
        .o_sdi(sdi), .o_sync_n(sync_n));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // Readback gives the select, the chosen word, then zeros.
    function automatic logic [31:0] rb_exp(input logic [7:0] s,
                                           input logic [15:0] c);
        return {s, c, 8'h00};
    endfunction
    // Strobe kept 1.6 us clear of the end of the last frame.
    task automatic load();
        repeat (80) @(posedge clk);
        ld_n <= 1'b0;
        repeat (10) @(posedge clk);
        ld_n <= 1'b1;
        repeat (10) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic conclude();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rstn = 1'b0;
        pin_rstn = 1'b1;
        ld_n = 1'b1;
        ce = 1'b1;
        seed = 32'hBF35;
        exp_code = 16'h0000;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk) chk(mod_en, 0);
        host_u.xfer({8'h02, 16'h0001, 8'h00}, 24, rd);
        @(negedge clk) chk(mod_en, 1);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            val = (i == 0) ? 16'hFFFF : seed[15:0];
            host_u.xfer({8'h01, val, 8'h00}, (i == 3) ? 23 : 24, rd);
            @(negedge clk) chk(code, exp_code);
            if (i < 3)
                exp_code = val;
            load();
            chk(code, exp_code);
        end
        host_u.xfer({8'h1F, 16'h0000, 8'h00}, 24, rd);
        host_u.xfer(32'h0, 32, rd);
        chk(rd, rb_exp(8'h00, exp_code));
        // Select the staged code, then general_config_one (modem bit on).
        for (int s = 1; s < 3; s++) begin
            host_u.xfer({8'h1F, 8'h00, 8'(s), 8'h00}, 24, rd);
            host_u.xfer(32'h0, 32, rd);
            chk(rd, rb_exp(8'(s), (s == 1) ? exp_code : 16'h0001));
        end
        host_u.xfer({8'h02, 16'h0002, 8'h00}, 24, rd);
        host_u.xfer({8'h01, 16'h1234, 8'h00}, 24, rd);
        host_u.xfer({8'h01, 16'h5A5A, 8'hC3}, 32, rd);
        load();
        chk({chk_en, mod_en, code}, {2'b10, 16'h5A5A});
        // With the clock enable low the strobe must leave the code alone.
        host_u.xfer({8'h01, 16'hA5A5, 8'h3C}, 32, rd);
        @(posedge clk) ce <= 1'b0;
        load();
        @(posedge clk) ce <= 1'b1;
        @(negedge clk) chk(code, 16'h5A5A);
        load();
        chk(code, 16'hA5A5);
        @(posedge clk) pin_rstn <= 1'b0;
        repeat (6) @(posedge clk);
        pin_rstn <= 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk) chk({chk_en, mod_en, oe, code}, 0);
        conclude();
    end
    initial begin
        #200000;
        miscompares++;
        conclude();
    end
endmodule
`default_nettype wire
